// [pkg/rftsq_pkg.sv]
// constants for the rx flow tag and start-of-packet queue select block
package rftsq_pkg;
  localparam logic [11:0] RFTSQ_CFG_C_ADDR  = 12'h008;
  localparam logic [11:0] RFTSQ_CFG_D_ADDR  = 12'h00c;
  localparam logic [11:0] RFTSQ_CFG_E_ADDR  = 12'h010;
  localparam logic [11:0] RFTSQ_CFG_F_ADDR  = 12'h014;
  localparam logic [11:0] RFTSQ_CFG_G_ADDR  = 12'h018;
  localparam logic [11:0] RFTSQ_CFG_B_ADDR  = 12'h004;
  localparam logic [11:0] RFTSQ_STAT_ADDR   = 12'h01c;
  localparam int          RFTSQ_SEL_LSB     = 16;
  localparam int          RFTSQ_EN_LSB      = 0;
  localparam int          RFTSQ_CONST_LSB   = 0;
  localparam int          RFTSQ_QMGR_LSB    = 28;
  localparam int          RFTSQ_QNUM_LSB    = 16;
  localparam int          RFTSQ_QMGR_LO_LSB = 12;
  localparam int          RFTSQ_QNUM_LO_LSB = 0;
  localparam int          RFTSQ_LIM_HI_LSB  = 16;
  localparam logic [2:0]  RFTSQ_SEL_RESET   = 3'h0;
  localparam logic [2:0]  RFTSQ_EN_RESET    = 3'h0;
  localparam logic [13:0] RFTSQ_QUEUE_RESET = 14'h0000;
  localparam logic [15:0] RFTSQ_LIM_RESET   = 16'h0000;
  localparam logic [7:0]  RFTSQ_CONST_RESET = 8'h00;
  localparam logic [2:0]  RFTSQ_SEL_KEEP    = 3'h0;
  localparam logic [2:0]  RFTSQ_SEL_CONST   = 3'h1;
  localparam logic [2:0]  RFTSQ_SEL_FLOW    = 3'h2;
  localparam logic [2:0]  RFTSQ_SEL_TAG_LO  = 3'h4;
  localparam logic [2:0]  RFTSQ_SEL_TAG_HI  = 3'h5;
  localparam int          RFTSQ_CLASSES     = 4;
endpackage

// [logic/rftsq_tag_mux.sv]
// low destination tag byte source selector
`timescale 1ns/10ps
module rftsq_tag_mux
  import rftsq_pkg::*;
(
  input  wire logic [2:0]  dest_tag_low_byte_select,
  input  wire logic [7:0]  dest_tag_low_constant,
  input  wire logic [7:0]  flow_identifier,
  input  wire logic [15:0] be_dest_tag,
  input  wire logic [7:0]  in_byte,
  output logic      [7:0]  out_byte
);
  always_comb begin
    case (dest_tag_low_byte_select)
      RFTSQ_SEL_KEEP:   out_byte = in_byte;
      RFTSQ_SEL_CONST:  out_byte = dest_tag_low_constant;
      RFTSQ_SEL_FLOW:   out_byte = flow_identifier;
      RFTSQ_SEL_TAG_LO: out_byte = be_dest_tag[7:0];
      RFTSQ_SEL_TAG_HI: out_byte = be_dest_tag[15:8];
      default:          out_byte = in_byte;
    endcase
  end
endmodule

// [logic/rftsq_size_class.sv]
// packet size class picker
`timescale 1ns/10ps
module rftsq_size_class
  import rftsq_pkg::*;
(
  input  wire logic [2:0]  size_limit_enable,
  input  wire logic [15:0] packet_size,
  input  wire logic [15:0] packet_size_limit_zero,
  input  wire logic [15:0] packet_size_limit_one,
  input  wire logic [15:0] packet_size_limit_two,
  output logic      [1:0]  size_class
);
  always_comb begin
    size_class = 2'h0;
    if (size_limit_enable[0]) begin
      if (packet_size <= packet_size_limit_zero) begin
        size_class = 2'h0;
      end else if (!size_limit_enable[1]) begin
        size_class = 2'h1;
      end else if (packet_size <= packet_size_limit_one) begin
        size_class = 2'h1;
      end else if (!size_limit_enable[2]) begin
        size_class = 2'h2;
      end else if (packet_size <= packet_size_limit_two) begin
        size_class = 2'h2;
      end else begin
        size_class = 2'h3;
      end
    end
  end
endmodule

// [logic/rftsq_top.sv]
// rx flow tag byte and start-of-packet queue select with apb registers
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/10ps
module rftsq_top
  import rftsq_pkg::*;
#(
  parameter bit SIZE_SELECT_SUPPORTED = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sop_valid,
  input  wire logic [15:0] packet_size,
  input  wire logic [7:0]  flow_identifier,
  input  wire logic [15:0] be_dest_tag,
  input  wire logic [31:0] descriptor_word1_in,
  output logic             sop_done,
  output logic [31:0]      descriptor_word1_out,
  output logic [1:0]       first_buffer_queue_manager,
  output logic [11:0]      first_buffer_queue_index
);
  logic [2:0]  dest_tag_low_byte_select_q;
  logic [2:0]  size_limit_enable_q;
  logic [7:0]  dest_tag_low_constant_q;
  logic [13:0] queue_q [RFTSQ_CLASSES];
  logic [15:0] packet_size_limit_zero_q;
  logic [15:0] packet_size_limit_one_q;
  logic [15:0] packet_size_limit_two_q;
  logic [1:0]  last_class_q;
  logic [7:0]  tag_byte;
  logic [1:0]  size_class;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] rd_d;

  function automatic logic [31:0] queue_pair(input logic [13:0] hi, input logic [13:0] lo);
    queue_pair = 32'h0000_0000;
    queue_pair[RFTSQ_QMGR_LSB +: 2]    = hi[13:12];
    queue_pair[RFTSQ_QNUM_LSB +: 12]   = hi[11:0];
    queue_pair[RFTSQ_QMGR_LO_LSB +: 2] = lo[13:12];
    queue_pair[RFTSQ_QNUM_LO_LSB +: 12] = lo[11:0];
  endfunction

  // zero-wait apb slave
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite && addr_ok;
  assign rd_en  = psel && !penable && !pwrite;
  always_comb begin
    case (paddr)
      RFTSQ_CFG_B_ADDR, RFTSQ_CFG_C_ADDR, RFTSQ_CFG_D_ADDR, RFTSQ_CFG_E_ADDR,
      RFTSQ_CFG_F_ADDR, RFTSQ_CFG_G_ADDR, RFTSQ_STAT_ADDR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  // selector and enable fields; reserved bits are never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dest_tag_low_byte_select_q <= RFTSQ_SEL_RESET;
      size_limit_enable_q        <= RFTSQ_EN_RESET;
    end else if (wr_en && paddr == RFTSQ_CFG_C_ADDR) begin
      if (pstrb[2]) begin
        dest_tag_low_byte_select_q <= pwdata[RFTSQ_SEL_LSB +: 3];
      end
      if (pstrb[0] && SIZE_SELECT_SUPPORTED) begin
        size_limit_enable_q <= pwdata[RFTSQ_EN_LSB +: 3];
      end
    end
  end

  // constant low destination byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dest_tag_low_constant_q <= RFTSQ_CONST_RESET;
    end else if (wr_en && paddr == RFTSQ_CFG_B_ADDR && pstrb[0]) begin
      dest_tag_low_constant_q <= pwdata[RFTSQ_CONST_LSB +: 8];
    end
  end

  // queue fields for the four size classes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < RFTSQ_CLASSES; i++) begin
        queue_q[i] <= RFTSQ_QUEUE_RESET;
      end
    end else if (wr_en && paddr == RFTSQ_CFG_D_ADDR) begin
      queue_q[0] <= {pwdata[RFTSQ_QMGR_LSB +: 2], pwdata[RFTSQ_QNUM_LSB +: 12]};
      queue_q[1] <= {pwdata[RFTSQ_QMGR_LO_LSB +: 2], pwdata[RFTSQ_QNUM_LO_LSB +: 12]};
    end else if (wr_en && paddr == RFTSQ_CFG_E_ADDR) begin
      queue_q[2] <= {pwdata[RFTSQ_QMGR_LSB +: 2], pwdata[RFTSQ_QNUM_LSB +: 12]};
      queue_q[3] <= {pwdata[RFTSQ_QMGR_LO_LSB +: 2], pwdata[RFTSQ_QNUM_LO_LSB +: 12]};
    end
  end

  // size limits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      packet_size_limit_zero_q <= RFTSQ_LIM_RESET;
      packet_size_limit_one_q  <= RFTSQ_LIM_RESET;
      packet_size_limit_two_q  <= RFTSQ_LIM_RESET;
    end else if (wr_en && paddr == RFTSQ_CFG_F_ADDR) begin
      packet_size_limit_zero_q <= pwdata[RFTSQ_LIM_HI_LSB +: 16];
      packet_size_limit_one_q  <= pwdata[15:0];
    end else if (wr_en && paddr == RFTSQ_CFG_G_ADDR) begin
      packet_size_limit_two_q <= pwdata[RFTSQ_LIM_HI_LSB +: 16];
    end
  end

  // read data, registered in the setup phase
  always_comb begin
    case (paddr)
      RFTSQ_CFG_B_ADDR: rd_d = {24'h000000, dest_tag_low_constant_q};
      RFTSQ_CFG_C_ADDR: rd_d = {13'h0000, dest_tag_low_byte_select_q, 13'h0000,
                                size_limit_enable_q};
      RFTSQ_CFG_D_ADDR: rd_d = queue_pair(queue_q[0], queue_q[1]);
      RFTSQ_CFG_E_ADDR: rd_d = queue_pair(queue_q[2], queue_q[3]);
      RFTSQ_CFG_F_ADDR: rd_d = {packet_size_limit_zero_q, packet_size_limit_one_q};
      RFTSQ_CFG_G_ADDR: rd_d = {packet_size_limit_two_q, 16'h0000};
      RFTSQ_STAT_ADDR:  rd_d = {30'h00000000, last_class_q};
      default:          rd_d = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rd_d;
    end
  end

  rftsq_tag_mux u_tag_mux (
    .dest_tag_low_byte_select (dest_tag_low_byte_select_q),
    .dest_tag_low_constant    (dest_tag_low_constant_q),
    .flow_identifier          (flow_identifier),
    .be_dest_tag              (be_dest_tag),
    .in_byte                  (descriptor_word1_in[7:0]),
    .out_byte                 (tag_byte)
  );

  rftsq_size_class u_size_class (
    .size_limit_enable      (size_limit_enable_q),
    .packet_size            (packet_size),
    .packet_size_limit_zero (packet_size_limit_zero_q),
    .packet_size_limit_one  (packet_size_limit_one_q),
    .packet_size_limit_two  (packet_size_limit_two_q),
    .size_class             (size_class)
  );

  // results captured on the start-of-packet strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sop_done                   <= 1'b0;
      descriptor_word1_out       <= 32'h0000_0000;
      first_buffer_queue_manager <= 2'h0;
      first_buffer_queue_index   <= 12'h000;
      last_class_q               <= 2'h0;
    end else begin
      sop_done <= sop_valid;
      if (sop_valid) begin
        descriptor_word1_out       <= {descriptor_word1_in[31:8], tag_byte};
        first_buffer_queue_manager <= queue_q[size_class][13:12];
        first_buffer_queue_index   <= queue_q[size_class][11:0];
        last_class_q               <= size_class;
      end
    end
  end
endmodule

// [tb/rftsq_properties.sv]
// port assertions for the tag byte and queue select block
`timescale 1ns/10ps
module rftsq_properties
  import rftsq_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sop_valid,
  input wire logic [31:0] descriptor_word1_in,
  input wire logic        sop_done,
  input wire logic [31:0] descriptor_word1_out,
  input wire logic [1:0]  first_buffer_queue_manager,
  input wire logic [11:0] first_buffer_queue_index
);
  logic acc;
  logic hit;
  assign acc = psel && penable;
  assign hit = paddr inside {RFTSQ_CFG_B_ADDR, RFTSQ_CFG_C_ADDR, RFTSQ_CFG_D_ADDR,
    RFTSQ_CFG_E_ADDR, RFTSQ_CFG_F_ADDR, RFTSQ_CFG_G_ADDR, RFTSQ_STAT_ADDR};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_done_follows_sop: assert property (sop_valid |=> sop_done)
    else $error("sop_done missing after sop_valid");
  a_done_only_sop: assert property (!sop_valid |=> !sop_done)
    else $error("sop_done without sop_valid");
  a_upper_word_kept: assert property (sop_valid |=>
    descriptor_word1_out[31:8] == $past(descriptor_word1_in[31:8]))
    else $error("descriptor word upper bits altered");
  a_outputs_held: assert property (!sop_valid |=> $stable(descriptor_word1_out)
    && $stable(first_buffer_queue_manager) && $stable(first_buffer_queue_index))
    else $error("outputs changed without sop");
  a_access_ready: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_unmapped_err: assert property (acc && !hit |-> pslverr)
    else $error("no error on unmapped access");
  a_mapped_ok: assert property (acc && hit |-> !pslverr)
    else $error("error on mapped access");
  a_setup_no_err: assert property (psel && !penable |-> !pslverr ##1 penable)
    else $error("error in setup phase");
endmodule
bind rftsq_top rftsq_properties u_props (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .sop_valid, .descriptor_word1_in, .sop_done, .descriptor_word1_out,
  .first_buffer_queue_manager, .first_buffer_queue_index);

// [tb/rftsq_backend_model.sv]
// back-end model presenting start-of-packet size and tags
`timescale 1ns/10ps
module rftsq_backend_model (
  input  wire logic        pclk,
  output logic             sop_valid,
  output logic [15:0]      packet_size,
  output logic [7:0]       flow_identifier,
  output logic [15:0]      be_dest_tag,
  output logic [31:0]      descriptor_word1_in
);
  initial begin
    sop_valid = 1'b0;
    packet_size = 16'h0;
    flow_identifier = 8'h0;
    be_dest_tag = 16'h0;
    descriptor_word1_in = 32'h0;
  end
  // size and tags are valid only with the pulse, inverted afterwards
  task automatic send(input logic [15:0] s, input logic [7:0] f, input logic [15:0] t,
                      input logic [31:0] w);
    @(posedge pclk);
    sop_valid <= 1'b1;
    packet_size <= s;
    flow_identifier <= f;
    be_dest_tag <= t;
    descriptor_word1_in <= w;
    @(posedge pclk);
    sop_valid <= 1'b0;
    packet_size <= ~s;
    flow_identifier <= ~f;
    be_dest_tag <= ~t;
    descriptor_word1_in <= ~w;
    #1;
  endtask
endmodule

// [tb/tb_rx_flow_tag_and_sop_queue_select.sv]
// self-checking bench for the tag byte and start-of-packet queue select
`timescale 1ns/10ps
module tb_rx_flow_tag_and_sop_queue_select;
  import rftsq_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata, descriptor_word1_in, descriptor_word1_out, rd;
  logic [15:0] packet_size, be_dest_tag;
  logic [7:0]  flow_identifier;
  logic [11:0] first_buffer_queue_index;
  logic [1:0]  first_buffer_queue_manager;
  logic        pready, pslverr, sop_valid, sop_done, err;
  int          error_cnt = 0;
  int          checked = 0;
  int          cycles = 0;
  always #12.5 pclk = ~pclk;
  rftsq_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .sop_valid, .packet_size, .flow_identifier, .be_dest_tag,
    .descriptor_word1_in, .sop_done, .descriptor_word1_out, .first_buffer_queue_manager,
    .first_buffer_queue_index);
  rftsq_backend_model bem (.pclk, .sop_valid, .packet_size, .flow_identifier, .be_dest_tag,
    .descriptor_word1_in);
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sop(input logic [15:0] s, input logic [31:0] w);
    bem.send(s, 8'h33, 16'h5544, w);
    cmp("sop_done", 32'h1, {31'h0, sop_done});
  endtask
  task automatic test_registers();
    apb(1'b0, RFTSQ_CFG_C_ADDR, 32'h0);
    cmp("reset value", 32'h0, rd);
    apb(1'b1, RFTSQ_CFG_C_ADDR, 32'hffffffff);
    apb(1'b0, RFTSQ_CFG_C_ADDR, 32'h0);
    cmp("reserved bits", 32'h0, rd & 32'h0000fff8);
    apb(1'b0, 12'h020, 32'h0);
    cmp("unmapped error", 32'h1, {31'h0, err});
    cmp("unmapped data", 32'h0, rd);
  endtask
  task automatic test_tag_select();
    logic [7:0] exp [8];
    exp = '{8'h11, 8'h22, 8'h33, 8'h11, 8'h44, 8'h55, 8'h11, 8'h11};
    apb(1'b1, RFTSQ_CFG_B_ADDR, 32'h22);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, RFTSQ_CFG_C_ADDR, 32'(s) << RFTSQ_SEL_LSB);
      sop(16'h0001, 32'habcdef11);
      cmp("tag byte", {24'h0, exp[s]}, descriptor_word1_out & 32'hff);
    end
  endtask
  task automatic test_queue_select();
    logic [2:0]  ens [4];
    logic [15:0] sizes [6];
    logic [13:0] q [4];
    int          c;
    ens = '{3'h0, 3'h1, 3'h3, 3'h7};
    sizes = '{16'd100, 16'd101, 16'd200, 16'd201, 16'd300, 16'd301};
    q = '{{2'h1, 12'h123}, {2'h2, 12'h456}, {2'h3, 12'h789}, {2'h0, 12'habc}};
    apb(1'b1, RFTSQ_CFG_D_ADDR, {2'h0, q[0], 2'h0, q[1]});
    apb(1'b1, RFTSQ_CFG_E_ADDR, {2'h0, q[2], 2'h0, q[3]});
    apb(1'b1, RFTSQ_CFG_F_ADDR, {16'd100, 16'd200});
    apb(1'b1, RFTSQ_CFG_G_ADDR, {16'd300, 16'h0});
    foreach (ens[e]) begin
      apb(1'b1, RFTSQ_CFG_C_ADDR, {29'h0, ens[e]});
      foreach (sizes[i]) begin
        c = 0;
        if (ens[e][0] && sizes[i] > 16'd100) c = 1;
        if (ens[e][1] && sizes[i] > 16'd200) c = 2;
        if (ens[e][2] && sizes[i] > 16'd300) c = 3;
        sop(sizes[i], 32'h0);
        cmp("queue", {18'h0, q[c]}, {18'h0, first_buffer_queue_manager,
          first_buffer_queue_index});
      end
    end
    apb(1'b0, RFTSQ_STAT_ADDR, 32'h0);
    cmp("last class", 32'h3, rd);
    apb(1'b0, RFTSQ_CFG_F_ADDR, 32'h0);
    cmp("limit word", {16'd100, 16'd200}, rd);
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    test_registers();
    test_tag_select();
    test_queue_select();
    print_verdict();
  end
endmodule
